//--- verilog/jtag_breakpoint_snooper.v
`include "jtag_snoop_defines.vh"

// Operation
// - Instruction register is four bits, loaded by shifting one code.
// - JTAG port active and debug clocking selected only while mode pin high.
// - Bypass code routes tdi to tdo through one stage.
// - Identification code instruction puts 32-bit id register between tdi and tdo.
// - Up to eight independently programmable breakpoints watch the processor buses.
// - Snooper works only while its enable register is set.
// - Interrupt clears the enable register and halts snooper logic.
// - Sixteen-bit event countdown drops by one on each event while nonzero.
// - Event while countdown reads zero raises the breakpoint interrupt.
// - Interrupt captures current instruction address into 16-bit register.
// - Each breakpoint owns configuration, match address and data registers.
// - Configuration: triggered bit 7, bus 6:5, access 4:3, condition 2:0.
// - The breakpoint causing the interrupt gets its triggered flag set.
// - Bus field: 00 instruction, 01 X data, 10 Y data; 11 forbidden.
// - Access 00 off, 01 fetch or read, 10 write, 11 both.
// - Condition 000 off, 001 address match only.
// - Condition 010 data equal, 011 data not equal.
// - Condition 100 signed less than, 101 signed greater or equal.
module jtag_breakpoint_snooper #(
  parameter NUM_BP  = 8,
  parameter AW      = 16,
  parameter DW      = 16,
  parameter ID_CODE = 32'h1234_5001  // Arbitrary value, bit 0 set per JTAG
) (
  input  wire          i_ref_clk,
  input  wire          i_rst_b,
  input  wire          i_dbg_mode,
  input  wire          i_tck,
  input  wire          i_tms,
  input  wire          i_tdi,
  input  wire [AW-1:0] i_ibus_addr,
  input  wire [DW-1:0] i_ibus_data,
  input  wire          i_ibus_fetch,
  input  wire [AW-1:0] i_xbus_addr,
  input  wire [DW-1:0] i_xbus_data,
  input  wire          i_xbus_rd,
  input  wire          i_xbus_wr,
  input  wire [AW-1:0] i_ybus_addr,
  input  wire [DW-1:0] i_ybus_data,
  input  wire          i_ybus_rd,
  input  wire          i_ybus_wr,
  output reg           o_tdo,
  output reg           o_dbg_clk_sel,
  output reg           o_bkpt_irq,
  output reg           o_snoop_active
);
  // TAP states, one-hot
  localparam ST_TLR  = 16'h0001;
  localparam ST_RTI  = 16'h0002;
  localparam ST_SDR  = 16'h0004;
  localparam ST_CDR  = 16'h0008;
  localparam ST_SHDR = 16'h0010;
  localparam ST_E1DR = 16'h0020;
  localparam ST_PDR  = 16'h0040;
  localparam ST_E2DR = 16'h0080;
  localparam ST_UDR  = 16'h0100;
  localparam ST_SIR  = 16'h0200;
  localparam ST_CIR  = 16'h0400;
  localparam ST_SHIR = 16'h0800;
  localparam ST_E1IR = 16'h1000;
  localparam ST_PIR  = 16'h2000;
  localparam ST_E2IR = 16'h4000;
  localparam ST_UIR  = 16'h8000;

  wire [3:0]          pins;
  wire                mode;
  wire                tck;
  wire                tms;
  wire                tdi;
  reg                 tck_d;
  wire                tck_rise;
  wire                tck_fall;
  reg  [15:0]         st;
  reg  [15:0]         next_st;
  reg  [`SNP_IR_W-1:0] ir_shift;
  reg  [`SNP_IR_W-1:0] ir;
  reg                 bypass;
  reg  [31:0]         id_shift;
  reg  [`SNP_DR_W-1:0] acc_shift;
  reg  [6:0]          acc_addr;
  reg  [DW-1:0]       rd_word;
  reg                 wr_stb;
  reg  [6:0]          wr_addr;
  reg  [DW-1:0]       wr_data;
  reg                 snoop_ena;
  reg  [15:0]         event_countdown;
  reg  [AW-1:0]       break_instr_addr;
  reg  [7:0]          bp_cfg  [0:NUM_BP-1];
  reg  [AW-1:0]       bp_addr [0:NUM_BP-1];
  reg  [DW-1:0]       bp_data [0:NUM_BP-1];
  wire [NUM_BP-1:0]   hit;
  wire                any_hit;
  wire                fire;
  integer             k;

  // Pins come from the probe, asynchronous to the core clock
  snoop_sync2 #(
    .W (4)
  ) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_async   ({i_dbg_mode, i_tck, i_tms, i_tdi}),
    .o_sync    (pins)
  );

  assign mode     = pins[3];
  assign tck      = pins[2];
  assign tms      = pins[1];
  assign tdi      = pins[0];
  assign tck_rise = tck & ~tck_d;
  assign tck_fall = ~tck & tck_d;

  // Edge detector on the synchronized test clock
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      tck_d <= 1'b0;
    else
      tck_d <= tck;
  end

  // TAP next state from tms
  always @*
  begin
    case (st)
      ST_TLR:  next_st = tms ? ST_TLR  : ST_RTI;
      ST_RTI:  next_st = tms ? ST_SDR  : ST_RTI;
      ST_SDR:  next_st = tms ? ST_SIR  : ST_CDR;
      ST_CDR:  next_st = tms ? ST_E1DR : ST_SHDR;
      ST_SHDR: next_st = tms ? ST_E1DR : ST_SHDR;
      ST_E1DR: next_st = tms ? ST_UDR  : ST_PDR;
      ST_PDR:  next_st = tms ? ST_E2DR : ST_PDR;
      ST_E2DR: next_st = tms ? ST_UDR  : ST_SHDR;
      ST_UDR:  next_st = tms ? ST_SDR  : ST_RTI;
      ST_SIR:  next_st = tms ? ST_TLR  : ST_CIR;
      ST_CIR:  next_st = tms ? ST_E1IR : ST_SHIR;
      ST_SHIR: next_st = tms ? ST_E1IR : ST_SHIR;
      ST_E1IR: next_st = tms ? ST_UIR  : ST_PIR;
      ST_PIR:  next_st = tms ? ST_E2IR : ST_PIR;
      ST_E2IR: next_st = tms ? ST_UIR  : ST_SHIR;
      ST_UIR:  next_st = tms ? ST_SDR  : ST_RTI;
      default: next_st = ST_TLR;
    endcase
  end

  // Register read mux for the access instruction
  always @*
  begin
    rd_word = `SNP_WORD_RST;
    if (acc_addr[6:5] == `SNP_BP_REGION)
    begin
      case (acc_addr[1:0])
        `SNP_BP_SEL_CFG:  rd_word = {{(DW-8){1'b0}}, bp_cfg[acc_addr[4:2]]};
        `SNP_BP_SEL_ADDR: rd_word = bp_addr[acc_addr[4:2]];
        `SNP_BP_SEL_DATA: rd_word = bp_data[acc_addr[4:2]];
        default:          rd_word = `SNP_WORD_RST;
      endcase
    end
    else
    begin
      case (acc_addr)
        `SNP_REG_ENABLE: rd_word = {{(DW-1){1'b0}}, snoop_ena};
        `SNP_REG_EVENT_COUNTDOWN:   rd_word = event_countdown;
        `SNP_REG_BREAK_INSTR_ADDR:  rd_word = break_instr_addr;
        default:         rd_word = `SNP_WORD_RST;
      endcase
    end
  end

  // TAP sequencing; held in reset while debug mode is low
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b || !mode)
    begin
      st        <= ST_TLR;
      ir        <= `SNP_IR_IDCODE;
      ir_shift  <= `SNP_IR_CAPTURE;
      bypass    <= 1'b0;
      id_shift  <= 32'h0000_0000;
      acc_shift <= {`SNP_DR_W{1'b0}};
      acc_addr  <= 7'h00;
      o_tdo     <= 1'b0;
      wr_stb    <= 1'b0;
      wr_addr   <= 7'h00;
      wr_data   <= `SNP_WORD_RST;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (tck_rise)
      begin
        st <= next_st;
        if (st == ST_TLR)
          ir <= `SNP_IR_IDCODE;
        if (st == ST_CIR)
          ir_shift <= `SNP_IR_CAPTURE;
        if (st == ST_SHIR)
          ir_shift <= {tdi, ir_shift[`SNP_IR_W-1:1]};
        if (st == ST_CDR)
        begin
          bypass    <= 1'b0;
          id_shift  <= ID_CODE;
          acc_shift <= {1'b0, acc_addr, rd_word};
        end
        if (st == ST_SHDR)
        begin
          case (ir)
            `SNP_IR_IDCODE: id_shift  <= {tdi, id_shift[31:1]};
            `SNP_IR_ACCESS: acc_shift <= {tdi, acc_shift[`SNP_DR_W-1:1]};
            default:        bypass    <= tdi;
          endcase
        end
      end
      if (tck_fall)
      begin
        // Data changes on the falling edge so the probe samples it stable
        if (st == ST_SHIR)
          o_tdo <= ir_shift[0];
        else if (st == ST_SHDR)
        begin
          case (ir)
            `SNP_IR_IDCODE: o_tdo <= id_shift[0];
            `SNP_IR_ACCESS: o_tdo <= acc_shift[0];
            default:        o_tdo <= bypass;
          endcase
        end
        if (st == ST_UIR)
          ir <= ir_shift;
        if (st == ST_UDR && ir == `SNP_IR_ACCESS)
        begin
          acc_addr <= acc_shift[`SNP_DR_ADDR_HI:`SNP_DR_ADDR_LO];
          wr_stb   <= acc_shift[`SNP_DR_WR_BIT];
          wr_addr  <= acc_shift[`SNP_DR_ADDR_HI:`SNP_DR_ADDR_LO];
          wr_data  <= acc_shift[`SNP_DR_DATA_HI:`SNP_DR_DATA_LO];
        end
      end
    end
  end

  // Debug clock select follows the synchronized mode pin
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
      o_dbg_clk_sel <= 1'b0;
    else
      o_dbg_clk_sel <= mode;
  end

  // One matcher per breakpoint
  genvar g;
  generate
    for (g = 0; g < NUM_BP; g = g + 1)
    begin : g_bp
      snoop_bkpt_match #(
        .AW (AW),
        .DW (DW)
      ) u_match (
        .i_cfg        (bp_cfg[g]),
        .i_match_addr (bp_addr[g]),
        .i_match_data (bp_data[g]),
        .i_ibus_addr  (i_ibus_addr),
        .i_ibus_data  (i_ibus_data),
        .i_ibus_fetch (i_ibus_fetch),
        .i_xbus_addr  (i_xbus_addr),
        .i_xbus_data  (i_xbus_data),
        .i_xbus_rd    (i_xbus_rd),
        .i_xbus_wr    (i_xbus_wr),
        .i_ybus_addr  (i_ybus_addr),
        .i_ybus_data  (i_ybus_data),
        .i_ybus_rd    (i_ybus_rd),
        .i_ybus_wr    (i_ybus_wr),
        .o_hit        (hit[g])
      );
    end
  endgenerate

  // Disabled snooper sees no events at all
  assign any_hit = snoop_ena & (|hit);
  assign fire    = any_hit & (event_countdown == 16'h0000);

  // Snooper registers: debugger writes, hardware event updates
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      snoop_ena        <= 1'b0;
      event_countdown  <= `SNP_WORD_RST;
      break_instr_addr <= `SNP_WORD_RST;
      o_bkpt_irq       <= 1'b0;
      o_snoop_active   <= 1'b0;
      for (k = 0; k < NUM_BP; k = k + 1)
      begin
        bp_cfg[k]  <= `SNP_CFG_RST;
        bp_addr[k] <= `SNP_WORD_RST;
        bp_data[k] <= `SNP_WORD_RST;
      end
    end
    else
    begin
      if (wr_stb)
      begin
        if (wr_addr[6:5] == `SNP_BP_REGION)
        begin
          case (wr_addr[1:0])
            `SNP_BP_SEL_CFG:  bp_cfg[wr_addr[4:2]]  <= wr_data[7:0];
            `SNP_BP_SEL_ADDR: bp_addr[wr_addr[4:2]] <= wr_data;
            `SNP_BP_SEL_DATA: bp_data[wr_addr[4:2]] <= wr_data;
            default:          bp_cfg[wr_addr[4:2]]  <= bp_cfg[wr_addr[4:2]];
          endcase
        end
        else if (wr_addr == `SNP_REG_ENABLE)
          snoop_ena <= wr_data[0];
        else if (wr_addr == `SNP_REG_EVENT_COUNTDOWN)
          event_countdown <= wr_data;
      end
      // Counting; an event while countdown is nonzero overrides a same-cycle countdown write
      if (any_hit && event_countdown != 16'h0000)
        event_countdown <= event_countdown - 16'h0001;
      // Interrupt clears enable and wins over a same-cycle debugger write
      if (fire)
      begin
        snoop_ena        <= 1'b0;
        break_instr_addr <= i_ibus_addr;
        for (k = 0; k < NUM_BP; k = k + 1)
          if (hit[k])
            bp_cfg[k][`BP_TRIG] <= 1'b1;
      end
      o_bkpt_irq     <= fire;
      o_snoop_active <= snoop_ena & ~fire;
    end
  end
endmodule

//--- pkg/jtag_snoop_defines.vh
`ifndef JTAG_SNOOP_DEFINES_VH
`define JTAG_SNOOP_DEFINES_VH

// Instruction register
`define SNP_IR_W          4
`define SNP_IR_BYPASS     4'h0
`define SNP_IR_IDCODE     4'hF
`define SNP_IR_ACCESS     4'h8
`define SNP_IR_CAPTURE    4'h1

// Register access data register: {write, address, data}
`define SNP_DR_W          24
`define SNP_DR_WR_BIT     23
`define SNP_DR_ADDR_HI    22
`define SNP_DR_ADDR_LO    16
`define SNP_DR_DATA_HI    15
`define SNP_DR_DATA_LO    0

// Register indices
`define SNP_REG_ENABLE    7'h00
`define SNP_REG_EVENT_COUNTDOWN      7'h01
`define SNP_REG_BREAK_INSTR_ADDR     7'h02
`define SNP_BP_REGION     2'h1
`define SNP_BP_SEL_CFG    2'h0
`define SNP_BP_SEL_ADDR   2'h1
`define SNP_BP_SEL_DATA   2'h2

// Breakpoint configuration fields
`define BP_TRIG           7
`define BP_BUS_HI         6
`define BP_BUS_LO         5
`define BP_ACC_HI         4
`define BP_ACC_LO         3
`define BP_COND_HI        2
`define BP_COND_LO        0

// Field encodings
`define BP_BUS_I          2'h0
`define BP_BUS_X          2'h1
`define BP_BUS_Y          2'h2
`define BP_COND_ANY       3'h1
`define BP_COND_EQ        3'h2
`define BP_COND_NE        3'h3
`define BP_COND_LT        3'h4
`define BP_COND_GE        3'h5

// Reset values
`define SNP_CFG_RST       8'h00
`define SNP_WORD_RST      16'h0000

`endif

//--- verilog/snoop_sync2.v
// Two-stage synchronizer for pin levels
module snoop_sync2 #(
  parameter W = 1
) (
  input  wire         i_ref_clk,
  input  wire         i_rst_b,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] meta;

  // First stage feeds only the second
  always @(posedge i_ref_clk)
  begin
    if (!i_rst_b)
    begin
      meta   <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule

//--- verilog/snoop_bkpt_match.v
`include "jtag_snoop_defines.vh"

// Match logic for one breakpoint, purely combinational
module snoop_bkpt_match #(
  parameter AW = 16,
  parameter DW = 16
) (
  input  wire [7:0]    i_cfg,
  input  wire [AW-1:0] i_match_addr,
  input  wire [DW-1:0] i_match_data,
  input  wire [AW-1:0] i_ibus_addr,
  input  wire [DW-1:0] i_ibus_data,
  input  wire          i_ibus_fetch,
  input  wire [AW-1:0] i_xbus_addr,
  input  wire [DW-1:0] i_xbus_data,
  input  wire          i_xbus_rd,
  input  wire          i_xbus_wr,
  input  wire [AW-1:0] i_ybus_addr,
  input  wire [DW-1:0] i_ybus_data,
  input  wire          i_ybus_rd,
  input  wire          i_ybus_wr,
  output reg           o_hit
);
  reg [AW-1:0] bus_addr;
  reg [DW-1:0] bus_data;
  reg          bus_rd;
  reg          bus_wr;
  reg          bus_ok;
  reg          cond_ok;
  wire [1:0]   bus_sel;
  wire [1:0]   acc;
  wire [2:0]   cond;

  assign bus_sel = i_cfg[`BP_BUS_HI:`BP_BUS_LO];
  assign acc     = i_cfg[`BP_ACC_HI:`BP_ACC_LO];
  assign cond    = i_cfg[`BP_COND_HI:`BP_COND_LO];

  // Signed less-than on two data words
  function sgn_lt;
    input [DW-1:0] a;
    input [DW-1:0] b;
    begin
      sgn_lt = ($signed(a) < $signed(b));
    end
  endfunction

  // Bus selection; code 11 leaves the breakpoint dead
  always @*
  begin
    bus_ok   = 1'b1;
    bus_addr = i_ibus_addr;
    bus_data = i_ibus_data;
    bus_rd   = i_ibus_fetch;   // Fetch counts as a read
    bus_wr   = 1'b0;
    case (bus_sel)
      `BP_BUS_I: bus_ok = 1'b1;
      `BP_BUS_X:
      begin
        bus_addr = i_xbus_addr;
        bus_data = i_xbus_data;
        bus_rd   = i_xbus_rd;
        bus_wr   = i_xbus_wr;
      end
      `BP_BUS_Y:
      begin
        bus_addr = i_ybus_addr;
        bus_data = i_ybus_data;
        bus_rd   = i_ybus_rd;
        bus_wr   = i_ybus_wr;
      end
      default: bus_ok = 1'b0;
    endcase
  end

  // Data condition; 000, 110 and 111 never fire
  always @*
  begin
    case (cond)
      `BP_COND_ANY: cond_ok = 1'b1;
      `BP_COND_EQ:  cond_ok = (bus_data == i_match_data);
      `BP_COND_NE:  cond_ok = (bus_data != i_match_data);
      `BP_COND_LT:  cond_ok = sgn_lt(bus_data, i_match_data);
      `BP_COND_GE:  cond_ok = ~sgn_lt(bus_data, i_match_data);
      default:      cond_ok = 1'b0;
    endcase
  end

  // Access type bit 0 watches reads, bit 1 writes; 00 disables
  always @*
  begin
    o_hit = bus_ok & cond_ok & (bus_addr == i_match_addr)
          & ((acc[0] & bus_rd) | (acc[1] & bus_wr));
  end
endmodule

//--- verif/jtag_snoop_properties.sv
module jtag_snoop_properties (
  input logic i_ref_clk,
  input logic i_rst_b,
  input logic i_dbg_mode,
  input logic i_tck,
  input logic i_ibus_fetch,
  input logic i_xbus_rd,
  input logic i_xbus_wr,
  input logic i_ybus_rd,
  input logic i_ybus_wr,
  input logic o_tdo,
  input logic o_dbg_clk_sel,
  input logic o_bkpt_irq,
  input logic o_snoop_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  // Any bus strobe in the cycle
  wire any_acc;
  assign any_acc = i_ibus_fetch | i_xbus_rd | i_xbus_wr | i_ybus_rd | i_ybus_wr;

  // Interrupt is one pulse, then snooper halted
  AST_IRQ_PULSE: assert property (o_bkpt_irq |=> !o_bkpt_irq)
    else $error("interrupt longer than one cycle");
  AST_IRQ_STOPS: assert property (o_bkpt_irq |-> !o_snoop_active && $past(o_snoop_active))
    else $error("interrupt without enable drop");
  AST_IRQ_CAUSE: assert property (o_bkpt_irq |-> $past(any_acc))
    else $error("interrupt without a bus access");
  // Debug clocking follows the mode pin after synchronizing
  AST_CLKSEL_ON: assert property (i_dbg_mode [*5] |-> o_dbg_clk_sel)
    else $error("debug clock select not set");
  AST_CLKSEL_OFF: assert property (!i_dbg_mode [*5] |-> !o_dbg_clk_sel)
    else $error("debug clock select not cleared");
  // Port dead while mode pin is low
  AST_TDO_IDLE: assert property (!i_dbg_mode [*8] |-> $stable(o_tdo))
    else $error("tdo moves outside debug mode");
  // Shift output only moves while test clock low
  // One cycle back only: a pin edge landing on the clock edge may pass the first flop a cycle early
  AST_TDO_AFTER_FALL: assert property ($changed(o_tdo) && o_dbg_clk_sel |-> !$past(i_tck))
    else $error("tdo changed away from falling edge");
  AST_RST_QUIET: assert property ($rose(i_rst_b) |-> !(o_tdo | o_dbg_clk_sel | o_bkpt_irq | o_snoop_active))
    else $error("outputs not idle after reset");
  AST_ACTIVE_RISE: assert property ($rose(o_snoop_active) |-> o_dbg_clk_sel)
    else $error("snooper enabled without debug port");
endmodule

bind jtag_breakpoint_snooper jtag_snoop_properties u_props (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_dbg_mode(i_dbg_mode), .i_tck(i_tck),
  .i_ibus_fetch(i_ibus_fetch), .i_xbus_rd(i_xbus_rd), .i_xbus_wr(i_xbus_wr),
  .i_ybus_rd(i_ybus_rd), .i_ybus_wr(i_ybus_wr), .o_tdo(o_tdo), .o_dbg_clk_sel(o_dbg_clk_sel),
  .o_bkpt_irq(o_bkpt_irq), .o_snoop_active(o_snoop_active)
);

//--- verif/jtag_probe.sv
module jtag_probe (
  input  logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  timeunit 1ns;
  timeprecision 1ps;

  // Test clock parked low between scans
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // One 160 ns period; tdo taken at the rising edge
  task automatic tick(input logic ms, input logic di, output logic dout);
    o_tms = ms;
    o_tdi = di;
    #80 o_tck = 1'b1;
    dout = i_tdo;
    #80 o_tck = 1'b0;
  endtask

  // Five ones reach reset state, a zero parks in idle
  task automatic idle_reset();
    logic b;
    for (int i = 0; i < 6; i++) tick(i < 5, 1'b0, b);
  endtask

  // From idle: walk np tms bits, shift n bits LSB first, update, back to idle
  task automatic scan(input logic [3:0] pre, input int np, input int n,
                      input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    #13;
    for (int i = 0; i < np; i++) tick(pre[i], 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
    o_tdi = ~o_tdi; // Released line shows no stale bit
  endtask
endmodule

//--- verif/tb_jtag_breakpoint_snooper.sv
`include "jtag_snoop_defines.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb_jtag_breakpoint_snooper;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = 32'h5A3C_0F01; // Arbitrary identity, bit 0 set
  logic        clk, rst_b, dbg_mode, tck, tms, tdi, tdo, clk_sel, irq, active;
  logic        ib_f, xb_r, xb_w, yb_r, yb_w;
  logic [15:0] ib_a, ib_d, xb_a, xb_d, yb_a, yb_d;
  int          mismatches, n_tests, n_irq;

  jtag_breakpoint_snooper #(.ID_CODE(ID)) dut_u (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_dbg_mode(dbg_mode), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_ibus_addr(ib_a), .i_ibus_data(ib_d), .i_ibus_fetch(ib_f), .i_xbus_addr(xb_a), .i_xbus_data(xb_d),
    .i_xbus_rd(xb_r), .i_xbus_wr(xb_w), .i_ybus_addr(yb_a), .i_ybus_data(yb_d), .i_ybus_rd(yb_r),
    .i_ybus_wr(yb_w), .o_tdo(tdo), .o_dbg_clk_sel(clk_sel), .o_bkpt_irq(irq), .o_snoop_active(active));
  jtag_probe u_probe (.i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

  // Core clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Pulses counted so no wait races the single-cycle interrupt
  always @(posedge clk) if (irq === 1'b1) n_irq <= n_irq + 1;

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Register access helpers over the test port
  function automatic logic [6:0] bpx(int n, logic [1:0] s);
    return {`SNP_BP_REGION, 3'(n), s};
  endfunction
  task automatic ir(input logic [3:0] code);
    logic [31:0] q;
    u_probe.scan(4'b0011, 4, 4, {28'h0, code}, q);
    `CHK("ir capture", 4'h1, q[3:0])
  endtask
  task automatic wr(input logic [6:0] idx, input logic [15:0] v);
    logic [31:0] q;
    u_probe.scan(4'b0001, 3, 24, {8'h0, 1'b1, idx, v}, q);
  endtask
  task automatic rchk(input string nm, input logic [6:0] idx, input logic [15:0] e);
    logic [31:0] q;
    u_probe.scan(4'b0001, 3, 24, {8'h0, 1'b0, idx, 16'h0}, q);
    u_probe.scan(4'b0001, 3, 24, {8'h0, 1'b0, idx, 16'h0}, q);
    `CHK(nm, e, q[15:0])
  endtask
  // Drop all strobes one edge later
  task automatic idle();
    @(posedge clk) #1;
    {ib_f, xb_r, xb_w, yb_r, yb_w} = 5'h00;
  endtask

  // Reference match: selected bus, access kind, address, data condition
  function automatic bit model_hit(logic [7:0] c, logic [15:0] ma, md);
    logic [15:0] a, d;
    logic        r, w;
    case (c[6:5])
      2'd0: {a, d, r, w} = {ib_a, ib_d, ib_f, 1'b0};
      2'd1: {a, d, r, w} = {xb_a, xb_d, xb_r, xb_w};
      2'd2: {a, d, r, w} = {yb_a, yb_d, yb_r, yb_w};
      default: return 0;
    endcase
    if (!((c[3] & r) | (c[4] & w)) || a !== ma) return 0;
    case (c[2:0])
      3'd1: return 1;
      3'd2: return d == md;
      3'd3: return d != md;
      3'd4: return $signed(d) < $signed(md);
      3'd5: return $signed(d) >= $signed(md);
      default: return 0;
    endcase
  endfunction

  // Hang guard
  initial
  begin
    repeat (99000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // Main sequence
  initial
  begin
    logic [15:0] ma, md;
    logic [7:0]  c;
    logic [31:0] q;
    logic        b;
    bit          h;
    int          e, n;
    void'($urandom(32'h9c14_c5bc));
    {rst_b, dbg_mode} = 2'b01;
    {ib_f, xb_r, xb_w, yb_r, yb_w} = 5'h00;
    {ib_a, ib_d, xb_a, xb_d, yb_a, yb_d} = '0;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (6) @(posedge clk);
    u_probe.idle_reset();
    u_probe.scan(4'b0001, 3, 32, 32'h0, q);
    `CHK("idcode", ID, q)
    ir(`SNP_IR_BYPASS);
    u_probe.scan(4'b0001, 3, 8, 32'h0000_00B5, q);
    `CHK("bypass", 8'(8'hB5 << 1), q[7:0])
    // Reset values, unmapped and read-only places
    ir(`SNP_IR_ACCESS);
    rchk("enable", `SNP_REG_ENABLE, 16'h0);
    rchk("countdown", `SNP_REG_EVENT_COUNTDOWN, 16'h0);
    rchk("cfg7", bpx(7, `SNP_BP_SEL_CFG), 16'h0);
    rchk("unmapped", 7'h7F, 16'h0);
    wr(`SNP_REG_BREAK_INSTR_ADDR, 16'hBEEF);
    rchk("brk addr ro", `SNP_REG_BREAK_INSTR_ADDR, 16'h0);
    // Countdown: ignored while off, then two counted, third fires
    wr(bpx(2, `SNP_BP_SEL_CFG), 16'h0029);
    wr(bpx(2, `SNP_BP_SEL_ADDR), 16'h0100);
    rchk("match addr", bpx(2, `SNP_BP_SEL_ADDR), 16'h0100);
    wr(`SNP_REG_EVENT_COUNTDOWN, 16'h0002);
    @(posedge clk) #1;
    {xb_a, xb_r} = {16'h0100, 1'b1};
    idle();
    rchk("count off", `SNP_REG_EVENT_COUNTDOWN, 16'h0002);
    wr(`SNP_REG_ENABLE, 16'h0001);
    for (int i = 1; i <= 4; i++)
    begin
      @(posedge clk) #1;
      {xb_a, xb_r, ib_a} = {16'h0100, 1'b1, 16'(i)};
    end
    idle();
    @(posedge clk) #1;
    `CHK("irq count", 1, n_irq)
    rchk("brk addr", `SNP_REG_BREAK_INSTR_ADDR, 16'h0003);
    rchk("countdown", `SNP_REG_EVENT_COUNTDOWN, 16'h0000);
    rchk("enable clr", `SNP_REG_ENABLE, 16'h0000);
    rchk("trig", bpx(2, `SNP_BP_SEL_CFG), 16'h00A9);
    wr(bpx(2, `SNP_BP_SEL_CFG), 16'h0000);
    // Every breakpoint, condition and bus code against the model
    for (int k = 0; k < 24; k++)
    begin
      n = k % 8;
      c = {1'b0, 2'((k + k / 8) % 4), 2'($urandom), 3'(k % 8)};
      ma = 16'($urandom);
      md = 16'($urandom);
      wr(bpx(n, `SNP_BP_SEL_CFG), {8'h0, c});
      wr(bpx(n, `SNP_BP_SEL_ADDR), ma);
      wr(bpx(n, `SNP_BP_SEL_DATA), md);
      wr(`SNP_REG_ENABLE, 16'h0001);
      e = n_irq;
      `CHK("active on", 1'b1, active)
      @(posedge clk) #1;
      {ib_f, xb_r, xb_w, yb_r, yb_w} = 5'($urandom);
      ib_a = ma ^ 16'($urandom % 4 == 0);
      xb_a = ma ^ 16'($urandom % 4 == 0);
      yb_a = ma ^ 16'($urandom % 4 == 0);
      ib_d = md + 16'($urandom % 3) - 16'd1;
      xb_d = md + 16'($urandom % 3) - 16'd1;
      yb_d = md + 16'($urandom % 3) - 16'd1;
      h = model_hit(c, ma, md);
      q[15:0] = ib_a;
      idle();
      @(posedge clk) #1;
      `CHK("irq", e + int'(h), n_irq)
      `CHK("active", !h, active)
      `CHK("irq low", 1'b0, irq)
      rchk("trig flag", bpx(n, `SNP_BP_SEL_CFG), {8'h0, h, c[6:0]});
      rchk("enable", `SNP_REG_ENABLE, {15'h0, !h});
      if (h) rchk("brk addr", `SNP_REG_BREAK_INSTR_ADDR, q[15:0]);
      wr(bpx(n, `SNP_BP_SEL_CFG), 16'h0000);
    end
    // Port ignored with mode pin low, reset state on return
    ir(`SNP_IR_BYPASS);
    @(posedge clk) #1 dbg_mode = 1'b0;
    repeat (8) @(posedge clk);
    `CHK("clk sel off", 1'b0, clk_sel)
    u_probe.scan(4'b0011, 4, 4, 32'h0, q);
    `CHK("tdo dead", 32'h0, q)
    @(posedge clk) #1 dbg_mode = 1'b1;
    repeat (8) @(posedge clk);
    `CHK("clk sel on", 1'b1, clk_sel)
    u_probe.tick(1'b0, 1'b0, b);
    u_probe.scan(4'b0001, 3, 32, 32'h0, q);
    `CHK("idcode again", ID, q)
    summarize();
  end
endmodule
